/* rcp_host.sv */
/*
 * Host controller model: drives the control pins and the second tick.
 * Assumes tb calls its tasks just after a rising pclk edge.
 */
`timescale 1ns/10ps
module rcp_host #(
  parameter int SEC_CYC = 3000
) (
  input wire logic pclk,
  output logic engine_power_req,
  output logic baud_set_select,
  output logic manual_reset_n,
  output logic standby_request_n,
  output logic clear_position_n,
  output logic gnss_second_tick
);
  // engine pin low at first reset so the engine must stay off
  rcp_pkg::rcp_pins_t pins = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  int tick_cnt = 0;

  assign engine_power_req = pins.engine_req;
  assign baud_set_select = pins.baud_sel;
  assign manual_reset_n = pins.manual_rst_n;
  assign standby_request_n = pins.standby_n;
  assign clear_position_n = pins.clear_pos_n;

  //////////////////////////////////////////////////////////////////////
  // shortened second: the real one would dominate the run time
  initial gnss_second_tick = 1'b0;
  always @(posedge pclk) begin
    tick_cnt <= (tick_cnt == SEC_CYC - 1) ? 0 : tick_cnt + 1;
    gnss_second_tick <= (tick_cnt == SEC_CYC - 1);
  end

  task automatic press(input int cyc);
    pins.clear_pos_n <= 1'b0;
    repeat (cyc) @(posedge pclk);
    pins.clear_pos_n <= 1'b1;
  endtask
endmodule

/* rcp_pkg.sv */
/*
 * Shared constants and types for the receiver control pin block:
 * register offsets, field positions, reset values, timing and modes.
 * Assumes a 100 MHz APB clock and firmware that decodes the serial
 * sentences and reports them through the register file.
 */
package rcp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam logic [11:0] CLR_SHORT_MS = 12'h05dc;
  localparam logic [11:0] CLR_LONG_MS = 12'h0bb8;
  localparam logic [11:0] CLR_SAT_MS = 12'h0bb9;
  localparam logic [2:0] POR_HOLD_CYC = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [11:0] REG_RUN_CTL = 12'h000;
  localparam logic [11:0] REG_PORT_CFG = 12'h004;
  localparam logic [11:0] REG_PPS_CFG = 12'h008;
  localparam logic [11:0] REG_FIX_CTL = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_IRQ_STAT = 12'h014;
  localparam logic [11:0] REG_IRQ_MASK = 12'h018;

  ////////////////////////////////////////////////////////////////////////
  // fields and reset values
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned FIX_VALID_BIT = 0;
  localparam int unsigned ALM_VALID_BIT = 1;
  localparam int unsigned PPS_EN_BIT = 0;
  localparam int unsigned PPS_WIDTH_LSB = 8;
  localparam logic [31:0] PORT_SET_A = 32'h0100_0802;
  localparam logic [31:0] PORT_SET_B = 32'h0100_0805;
  localparam logic [31:0] PPS_CFG_DEFAULT = 32'h0000_6401;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_CLR_SHORT = 0;
  localparam int unsigned IRQ_ERASE = 1;
  localparam int unsigned IRQ_ENGINE = 2;
  localparam int unsigned IRQ_MANRST = 3;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b001,
    MODE_POWER_SAVE = 3'b010,
    MODE_STANDBY = 3'b100
  } rcp_mode_t;

  typedef struct packed {
    logic engine_req;
    logic baud_sel;
    logic manual_rst_n;
    logic standby_n;
    logic clear_pos_n;
  } rcp_pins_t;

endpackage

/* rcp_top.sv */
/*
 * Control and status pin logic of the positioning receiver: engine
 * power control, stand-by, reset sources, serial port set selection,
 * pulse-per-second gating, almanac status, clear-position handling,
 * APB register file and interrupt.
 * Assumes pins are asynchronous to pclk, gnss_second_tick is a
 * one-cycle pulse on pclk, and firmware writes fix and almanac state.
 */
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps

module rcp_top #(
  parameter int unsigned MS_CYCLES = rcp_pkg::MS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic engine_power_req,
  input wire logic baud_set_select,
  input wire logic manual_reset_n,
  input wire logic standby_request_n,
  input wire logic clear_position_n,
  input wire logic gnss_second_tick,
  output logic pulse_second_out,
  output logic almanac_valid_out,
  output logic engine_enable,
  output logic rf_enable,
  output logic cpu_clock_enable,
  output logic [31:0] serial_port_cfg,
  output logic clear_position_pulse,
  output logic flash_erase_pulse,
  output logic flash_write_allow,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; pull-ups make every pin idle high
  rcp_pkg::rcp_pins_t pin_raw;
  rcp_pkg::rcp_pins_t pin_s1;
  rcp_pkg::rcp_pins_t pin_s2;
  rcp_pkg::rcp_pins_t pin_s3;
  rcp_pkg::rcp_pins_t pins;

  assign pin_raw = '{engine_req: engine_power_req,
                     baud_sel: baud_set_select,
                     manual_rst_n: manual_reset_n,
                     standby_n: standby_request_n,
                     clear_pos_n: clear_position_n};

  for (genvar i = 0; i < $bits(rcp_pkg::rcp_pins_t); i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_s1[i] <= 1'b1;
        pin_s2[i] <= 1'b1;
        pin_s3[i] <= 1'b1;
        pins[i] <= 1'b1;
      end else begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        // change accepted only once stages two and three agree
        if (pin_s2[i] == pin_s3[i]) begin
          pins[i] <= pin_s3[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset condition: held a few cycles after power-on so the
  // synchronisers have settled before the straps are sampled
  logic [2:0] por_cnt;
  logic reset_cond;
  logic man_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt <= 3'h0;
    end else if (por_cnt != rcp_pkg::POR_HOLD_CYC) begin
      por_cnt <= por_cnt + 3'h1;
    end
  end

  assign reset_cond = (por_cnt != rcp_pkg::POR_HOLD_CYC) |
                      ~pins.manual_rst_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      man_prev <= 1'b1;
    end else begin
      man_prev <= pins.manual_rst_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // millisecond enable
  logic [31:0] ms_cnt;
  logic ms_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else if (ms_cnt == 32'(MS_CYCLES - 1)) begin
      ms_cnt <= 32'h0000_0000;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt <= ms_cnt + 32'h0000_0001;
      ms_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait, data captured in setup so it leaves a flop
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_val;
  logic [31:0] pps_cfg;
  logic fix_valid;
  logic alm_valid;
  logic engine_on;
  logic baud_latched;
  logic [rcp_pkg::IRQ_W-1:0] irq_stat;
  logic [rcp_pkg::IRQ_W-1:0] irq_mask;
  rcp_pkg::rcp_mode_t mode;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & pready;
  assign wr_en = access_ph & pwrite & ~pslverr;

  always_comb begin
    rd_val = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == rcp_pkg::REG_RUN_CTL) begin
      rd_val[rcp_pkg::RUN_BIT] = engine_on;
    end else if (paddr == rcp_pkg::REG_PORT_CFG) begin
      rd_val = serial_port_cfg;
    end else if (paddr == rcp_pkg::REG_PPS_CFG) begin
      rd_val = pps_cfg;
    end else if (paddr == rcp_pkg::REG_FIX_CTL) begin
      rd_val[rcp_pkg::FIX_VALID_BIT] = fix_valid;
      rd_val[rcp_pkg::ALM_VALID_BIT] = alm_valid;
    end else if (paddr == rcp_pkg::REG_STATUS) begin
      rd_val[7:0] = {flash_write_allow, mode, baud_latched,
                     almanac_valid_out, pulse_second_out, engine_on};
    end else if (paddr == rcp_pkg::REG_IRQ_STAT) begin
      rd_val[rcp_pkg::IRQ_W-1:0] = irq_stat;
    end else if (paddr == rcp_pkg::REG_IRQ_MASK) begin
      rd_val[rcp_pkg::IRQ_W-1:0] = irq_mask;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready <= 1'b1;
      pslverr <= ~addr_ok;
      prdata <= rd_val;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // firmware-owned state: fix and almanac verdicts, pulse config
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fix_valid <= 1'b0;
      alm_valid <= 1'b0;
    end else if (reset_cond) begin
      fix_valid <= 1'b0;
      alm_valid <= 1'b0;
    end else if (wr_en && paddr == rcp_pkg::REG_FIX_CTL) begin
      fix_valid <= pwdata[rcp_pkg::FIX_VALID_BIT];
      alm_valid <= pwdata[rcp_pkg::ALM_VALID_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pps_cfg <= rcp_pkg::PPS_CFG_DEFAULT;
    end else if (reset_cond) begin
      pps_cfg <= rcp_pkg::PPS_CFG_DEFAULT;
    end else if (wr_en && paddr == rcp_pkg::REG_PPS_CFG) begin
      pps_cfg <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial port settings; the port has no handshake lines, so the
  // settings carry no flow-control field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_port_cfg <= rcp_pkg::PORT_SET_A;
      baud_latched <= 1'b0;
    end else if (reset_cond) begin
      serial_port_cfg <= pins.baud_sel ? rcp_pkg::PORT_SET_B
                                       : rcp_pkg::PORT_SET_A;
      baud_latched <= pins.baud_sel;
    end else if (wr_en && paddr == rcp_pkg::REG_PORT_CFG) begin
      serial_port_cfg <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // engine power
  logic eng_prev;
  logic eng_rise;
  logic eng_fall;
  logic run_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_prev <= 1'b1;
    end else begin
      eng_prev <= pins.engine_req;
    end
  end

  assign eng_rise = pins.engine_req & ~eng_prev;
  assign eng_fall = ~pins.engine_req & eng_prev;
  assign run_wr = wr_en && paddr == rcp_pkg::REG_RUN_CTL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_on <= 1'b0;
    end else if (reset_cond) begin
      engine_on <= pins.engine_req;
    end else if (eng_rise) begin
      engine_on <= 1'b1;
    end else if (eng_fall) begin
      engine_on <= 1'b0;
    end else if (run_wr && !pins.engine_req) begin
      // the sentence only overrides while the pin is low
      engine_on <= pwdata[rcp_pkg::RUN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operating mode and power gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= rcp_pkg::MODE_POWER_SAVE;
    end else if (!pins.standby_n) begin
      mode <= rcp_pkg::MODE_STANDBY;
    end else if (engine_on && !reset_cond) begin
      // not active until the straps have settled: no engine glitch
      mode <= rcp_pkg::MODE_ACTIVE;
    end else begin
      mode <= rcp_pkg::MODE_POWER_SAVE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_enable <= 1'b0;
      engine_enable <= 1'b0;
      cpu_clock_enable <= 1'b1;
    end else begin
      case (mode)
        rcp_pkg::MODE_ACTIVE: begin
          rf_enable <= 1'b1;
          engine_enable <= 1'b1;
          cpu_clock_enable <= 1'b1;
        end
        rcp_pkg::MODE_STANDBY: begin
          rf_enable <= 1'b0;
          engine_enable <= 1'b0;
          cpu_clock_enable <= 1'b0;
        end
        default: begin
          rf_enable <= 1'b0;
          engine_enable <= 1'b0;
          cpu_clock_enable <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // almanac status, meaningful in active mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      almanac_valid_out <= 1'b0;
    end else begin
      almanac_valid_out <= alm_valid &&
                           mode == rcp_pkg::MODE_ACTIVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse per second; width counted in milliseconds
  logic pps_allowed;
  logic [7:0] pps_left;
  logic [7:0] pps_width;

  assign pps_allowed = fix_valid && mode == rcp_pkg::MODE_ACTIVE;
  assign pps_width = pps_cfg[rcp_pkg::PPS_WIDTH_LSB +: 8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_second_out <= 1'b0;
      pps_left <= 8'h00;
    end else if (!pps_allowed) begin
      pulse_second_out <= 1'b0;
      pps_left <= 8'h00;
    end else if (gnss_second_tick && pps_cfg[rcp_pkg::PPS_EN_BIT]) begin
      pulse_second_out <= 1'b1;
      // a zero width would never show, so it counts as one
      pps_left <= (pps_width == 8'h00) ? 8'h01 : pps_width;
    end else if (ms_tick && pulse_second_out) begin
      if (pps_left <= 8'h01) begin
        pulse_second_out <= 1'b0;
      end
      pps_left <= pps_left - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clear-position press length
  logic [11:0] clr_ms;
  logic clr_prev;
  logic clr_release;
  logic clr_short;
  logic clr_long_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_ms <= 12'h000;
      clr_prev <= 1'b1;
    end else begin
      clr_prev <= pins.clear_pos_n;
      if (pins.clear_pos_n && clr_prev) begin
        clr_ms <= 12'h000;
      end else if (!pins.clear_pos_n && ms_tick &&
                   clr_ms != rcp_pkg::CLR_SAT_MS) begin
        clr_ms <= clr_ms + 12'h001;
      end
    end
  end

  assign clr_release = pins.clear_pos_n & ~clr_prev;
  // presses from 1.5 s up to the erase point fall in neither class
  assign clr_short = clr_ms < rcp_pkg::CLR_SHORT_MS;
  assign clr_long_hit = !pins.clear_pos_n && ms_tick &&
                        clr_ms == rcp_pkg::CLR_LONG_MS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_position_pulse <= 1'b0;
      flash_erase_pulse <= 1'b0;
    end else begin
      clear_position_pulse <= clr_release && clr_short &&
                              !fix_valid;
      flash_erase_pulse <= clr_long_hit;
    end
  end

  // a cleared position is not trusted for backup until a fresh fix
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_write_allow <= 1'b1;
    end else if (clear_position_pulse || flash_erase_pulse) begin
      flash_write_allow <= 1'b0;
    end else if (fix_valid) begin
      flash_write_allow <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: read clears only bits returned, so a set wins
  logic [rcp_pkg::IRQ_W-1:0] irq_evt;
  logic [rcp_pkg::IRQ_W-1:0] irq_rdclr;

  always_comb begin
    irq_evt = '0;
    irq_evt[rcp_pkg::IRQ_CLR_SHORT] = clear_position_pulse;
    irq_evt[rcp_pkg::IRQ_ERASE] = flash_erase_pulse;
    // filter settling after reset is not a pin edge
    irq_evt[rcp_pkg::IRQ_ENGINE] = (eng_rise | eng_fall) & ~reset_cond;
    irq_evt[rcp_pkg::IRQ_MANRST] = ~pins.manual_rst_n & man_prev;
    irq_rdclr = '0;
    if (access_ph && !pwrite && paddr == rcp_pkg::REG_IRQ_STAT) begin
      irq_rdclr = prdata[rcp_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_rdclr) | irq_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (wr_en && paddr == rcp_pkg::REG_IRQ_MASK) begin
      irq_mask <= pwdata[rcp_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_standby_req;
    !pins.standby_n;
  endsequence

  sequence s_standby_out;
    mode == rcp_pkg::MODE_STANDBY ##1 !cpu_clock_enable && !rf_enable;
  endsequence

  engine_rise_on_a: assert property (
    eng_rise && !reset_cond |=> engine_on)
    else $error("engine not started on request rise");

  engine_strap_off_a: assert property (
    reset_cond && !pins.engine_req |=> !engine_on)
    else $error("engine started with request low at reset");

  engine_fall_off_a: assert property (
    eng_fall && !reset_cond |=> !engine_on)
    else $error("engine not stopped on request fall");

  baud_strap_a: assert property (
    reset_cond |=> serial_port_cfg ==
      ($past(pins.baud_sel) ? rcp_pkg::PORT_SET_B : rcp_pkg::PORT_SET_A))
    else $error("serial settings not taken from selected set");

  pps_gate_low_a: assert property (
    !pps_allowed |=> !pulse_second_out)
    else $error("second pulse while not fixing");

  pps_edge_tick_a: assert property (
    $rose(pulse_second_out) |-> $past(gnss_second_tick))
    else $error("second pulse rose off the second boundary");

  pps_cfg_reset_a: assert property (
    reset_cond |=> pps_cfg == rcp_pkg::PPS_CFG_DEFAULT)
    else $error("pulse config not reloaded at reset");

  almanac_gate_a: assert property (
    mode != rcp_pkg::MODE_ACTIVE |=> !almanac_valid_out)
    else $error("almanac output high outside active mode");

  standby_mode_a: assert property (
    s_standby_req |=> s_standby_out)
    else $error("stand-by request not obeyed");

  short_clear_a: assert property (
    clr_release && clr_ms < rcp_pkg::CLR_SHORT_MS && !fix_valid
    |=> clear_position_pulse)
    else $error("short clear press not acted on");

  clear_when_fix_a: assert property (
    clr_release && fix_valid |=> !clear_position_pulse)
    else $error("position cleared while fixing");

  long_erase_a: assert property (
    clr_long_hit |=> flash_erase_pulse ##1 !flash_write_allow)
    else $error("long clear press did not erase flash");

  mid_press_a: assert property (
    clr_release && clr_ms >= rcp_pkg::CLR_SHORT_MS
    |=> !clear_position_pulse && !flash_erase_pulse)
    else $error("middle-length press acted on");

endmodule

/* tb.sv */
/*
 * Self-checking bench for the receiver control pin block.
 * Assumes rcp_top with MS_CYCLES=10 and the rcp_host pin model.
 */
`timescale 1ns/10ps
module tb;
  localparam int MS = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, spc, rd;
  logic pready, pslverr, err, eng, bsel, mrst_n, stby_n, clr_n, tick;
  logic pso, alm, eng_en, rf_en, cpu_en, clr_p, ers_p, fwa, irq;
  logic pso_q = 1'b0;
  logic tick_q = 1'b0;
  logic tick_q2 = 1'b0;
  int fails = 0;
  int num_checks = 0;
  int n_clr = 0;
  int n_ers = 0;
  int n_pps = 0;
  int n_late = 0;

  always #5 pclk = ~pclk;

  rcp_host host (.pclk(pclk), .engine_power_req(eng),
    .baud_set_select(bsel), .manual_reset_n(mrst_n),
    .standby_request_n(stby_n), .clear_position_n(clr_n),
    .gnss_second_tick(tick));

  rcp_top #(.MS_CYCLES(MS)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .engine_power_req(eng), .baud_set_select(bsel),
    .manual_reset_n(mrst_n), .standby_request_n(stby_n),
    .clear_position_n(clr_n), .gnss_second_tick(tick),
    .pulse_second_out(pso), .almanac_valid_out(alm),
    .engine_enable(eng_en), .rf_enable(rf_en),
    .cpu_clock_enable(cpu_en), .serial_port_cfg(spc),
    .clear_position_pulse(clr_p), .flash_erase_pulse(ers_p),
    .flash_write_allow(fwa), .irq(irq));

  //////////////////////////////////////////////////////////////////////
  // pulse counters; a second pulse must rise within 2 edges of a tick
  always @(posedge pclk) begin
    pso_q <= pso;
    tick_q <= tick;
    tick_q2 <= tick_q;
    if (clr_p) n_clr++;
    if (ers_p) n_ers++;
    if (pso && !pso_q) begin
      n_pps++;
      if (!(tick_q || tick_q2)) n_late++;
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001, "apb no answer");
  endtask

  task automatic settle;
    repeat (12) @(posedge pclk);
  endtask

  task automatic do_reset(input logic b);
    host.pins.baud_sel <= b;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(spc, rcp_pkg::PORT_SET_A, "port set a");
    chk(32'(eng_en), 32'h0000_0000, "engine off");
    chk(32'(alm), 32'h0000_0000, "almanac low");
    apb(1'b0, rcp_pkg::REG_PPS_CFG, 32'h0000_0000);
    chk(rd, rcp_pkg::PPS_CFG_DEFAULT, "pps default");
    apb(1'b1, 12'hff0, 32'h0000_0001);
    chk(32'(err), 32'h0000_0001, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
    $display("reset test done");
  endtask

  task automatic t_engine;
    host.pins.engine_req <= 1'b1;
    settle;
    chk(32'({eng_en, rf_en}), 32'h0000_0003, "pin rise");
    apb(1'b0, rcp_pkg::REG_STATUS, 32'h0000_0000);
    chk(32'(rd[6:4]), 32'h0000_0001, "active");
    host.pins.engine_req <= 1'b0;
    settle;
    chk(32'({eng_en, rf_en, cpu_en}), 32'h0000_0001, "pin fall");
    apb(1'b1, rcp_pkg::REG_RUN_CTL, 32'h0000_0001);
    settle;
    chk(32'(eng_en), 32'h0000_0001, "sentence on");
    apb(1'b1, rcp_pkg::REG_RUN_CTL, 32'h0000_0000);
    settle;
    chk(32'(eng_en), 32'h0000_0000, "sentence off");
    host.pins.engine_req <= 1'b1;
    settle;
    host.pins.standby_n <= 1'b0;
    settle;
    chk(32'({eng_en, rf_en, cpu_en}), 32'h0000_0000, "standby");
    host.pins.standby_n <= 1'b1;
    settle;
    chk(32'({eng_en, cpu_en}), 32'h0000_0003, "wake");
    $display("engine test done");
  endtask

  task automatic t_pps;
    repeat (3100) @(posedge pclk);
    chk(n_pps, 32'h0000_0000, "pps without fix");
    apb(1'b1, rcp_pkg::REG_FIX_CTL, 32'h0000_0003);
    settle;
    chk(32'(alm), 32'h0000_0001, "almanac valid");
    repeat (3100) @(posedge pclk);
    chk(n_pps, 32'h0000_0001, "pps while fixing");
    chk(n_late, 32'h0000_0000, "pps on tick");
    apb(1'b1, rcp_pkg::REG_FIX_CTL, 32'h0000_0000);
    repeat (1100) @(posedge pclk);
    chk(32'({pso, alm}), 32'h0000_0000, "fix lost");
    $display("pps test done");
  endtask

  task automatic t_clear;
    apb(1'b0, rcp_pkg::REG_IRQ_STAT, 32'h0000_0000);
    host.press(10 * MS);
    settle;
    chk(n_clr, 32'h0000_0001, "short press");
    chk(32'(irq), 32'h0000_0000, "masked");
    chk(32'(fwa), 32'h0000_0000, "no backup before fix");
    apb(1'b1, rcp_pkg::REG_FIX_CTL, 32'h0000_0001);
    host.press(10 * MS);
    settle;
    chk(n_clr, 32'h0000_0001, "ignored while fixing");
    chk(32'(fwa), 32'h0000_0001, "backup after fix");
    apb(1'b1, rcp_pkg::REG_FIX_CTL, 32'h0000_0000);
    host.press(2000 * MS);
    settle;
    chk(n_clr, 32'h0000_0001, "middle press clear");
    chk(n_ers, 32'h0000_0000, "middle press erase");
    apb(1'b0, rcp_pkg::REG_IRQ_STAT, 32'h0000_0000);
    chk(32'(rd[1:0]), 32'h0000_0001, "short flag");
    apb(1'b1, rcp_pkg::REG_IRQ_MASK, 32'h0000_0002);
    host.press(3100 * MS);
    settle;
    chk(n_ers, 32'h0000_0001, "long press");
    chk(32'({fwa, irq}), 32'h0000_0001, "erase blocks backup");
    apb(1'b0, rcp_pkg::REG_IRQ_STAT, 32'h0000_0000);
    chk(32'(rd[1]), 32'h0000_0001, "erase flag");
    settle;
    chk(32'(irq), 32'h0000_0000, "irq cleared");
    $display("clear test done");
  endtask

  task automatic t_resets;
    apb(1'b1, rcp_pkg::REG_PPS_CFG, 32'h0000_3200);
    apb(1'b0, rcp_pkg::REG_PPS_CFG, 32'h0000_0000);
    chk(rd, 32'h0000_3200, "pps changed");
    host.pins.manual_rst_n <= 1'b0;
    settle;
    host.pins.manual_rst_n <= 1'b1;
    settle;
    apb(1'b0, rcp_pkg::REG_IRQ_STAT, 32'h0000_0000);
    chk(32'(rd[3]), 32'h0000_0001, "manual reset seen");
    apb(1'b0, rcp_pkg::REG_PPS_CFG, 32'h0000_0000);
    chk(rd, rcp_pkg::PPS_CFG_DEFAULT, "pps reloaded");
    apb(1'b1, rcp_pkg::REG_PORT_CFG, 32'h0000_1234);
    settle;
    chk(spc, 32'h0000_1234, "port sentence");
    do_reset(1'b1);
    chk(spc, rcp_pkg::PORT_SET_B, "port set b");
    chk(32'(eng_en), 32'h0000_0001, "on at reset");
    $display("reset source test done");
  endtask

  initial begin
    do_reset(1'b0);
    t_reset;
    t_engine;
    t_pps;
    t_clear;
    t_resets;
    end_sim;
  end

  initial begin
    repeat (90000) @(posedge pclk);
    fails++;
    end_sim;
  end
endmodule
